/* core/sdadc_pkg.sv */
// Constants for the delta-sigma conversion sequencer.
// Assumes one system clock at 100 MHz and a plain register port.
// Functional notes
// - Four modes: single, continuous, multi, turbo.
// - Start by control bit or start input.
// - Completion sets status, end output until read.
// - Single: four conversions, first three prime.
// - Single mode idles in standby between triggers.
// - Continuous: three periods priming, then every period.
// - Multi mode resets decimator between samples.
// - Multi mode restarts next sample automatically.
// - Turbo: multi below 17 bits, else continuous.
// - Output depends on last four decimation periods of samples.
// - End output rises after every non-priming conversion.
// - Resolution chosen against maximum sample rate.
// - Decimator is fourth-order sinc filter.
package sdadc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_MASK   = 4'h2;
    localparam logic [3:0] ADDR_RESULT = 4'h3;
    localparam logic [3:0] ADDR_DECIM  = 4'h4;
    // CTRL layout
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_EN_BIT    = 1;
    localparam int CTRL_MODE_LSB  = 2;
    localparam int CTRL_RES_LSB   = 4;
    // STATUS / MASK layout
    localparam int ST_EOC_BIT     = 0;
    localparam int ST_OVR_BIT     = 1;
    localparam int ST_WIDTH       = 2;
    // ------------------------------------------------------------
    // Modes and resolutions
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_CONT   = 2'b01,
        MODE_MULTI  = 2'b10,
        MODE_TURBO  = 2'b11
    } mode_e;
    typedef enum logic [1:0] {
        RES_8  = 2'b00,
        RES_12 = 2'b01,
        RES_16 = 2'b10,
        RES_20 = 2'b11
    } res_e;
    // Decimation ratio per resolution at a fixed modulator rate
    localparam logic [15:0] DECIM_8     = 16'h0010;
    localparam logic [15:0] DECIM_12    = 16'h0020;
    localparam logic [15:0] DECIM_16    = 16'h0080;
    localparam logic [15:0] DECIM_20    = 16'h8000;
    localparam logic [2:0]  PRIME_CONV  = 3'h3;
    localparam int          SINC_ORDER  = 4;
    localparam int          ACC_W       = 64;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
    typedef enum logic [1:0] {
        SEQ_STANDBY = 2'b00,
        SEQ_PRIME   = 2'b01,
        SEQ_RUN     = 2'b10
    } seq_e;
endpackage

/* core/sinc4_decimator.sv */
// Fourth-order sinc decimator for a one-bit modulator stream.
// Assumes modulator bits arrive synchronised to i_clk with a valid strobe.
`timescale 1ns/1ps
`default_nettype none
module sinc4_decimator #(
    parameter int W = sdadc_pkg::ACC_W
) (
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    // Control
    input  wire logic          i_clear,
    input  wire logic [15:0]   i_ratio,
    // Modulator stream
    input  wire logic          i_bit_valid,
    input  wire logic          i_bit,
    // Output word
    output logic               o_valid,
    output logic [W-1:0]       o_word
);
    // ------------------------------------------------------------
    // Integrators and combs
    // ------------------------------------------------------------
    localparam int N = sdadc_pkg::SINC_ORDER;
    logic [W-1:0] integ [0:N];
    logic [W-1:0] comb  [0:N];
    logic [W-1:0] dly   [1:N];
    logic [15:0]  cnt;
    wire          tick = i_bit_valid && (cnt == i_ratio - 16'h0001);
    assign integ[0] = {{(W-1){1'b0}}, i_bit};
    genvar g;
    generate
        for (g = 1; g <= N; g++) begin : g_stage
            logic [W-1:0] acc;
            always_ff @(posedge i_clk) begin
                if (!i_rst_n || i_clear) begin
                    acc    <= '0;
                    dly[g] <= '0;
                end else begin
                    if (i_bit_valid)
                        acc <= acc + integ[g-1];
                    if (tick)
                        dly[g] <= comb[g-1];
                end
            end
            assign integ[g] = acc;
            assign comb[g]  = comb[g-1] - dly[g];
        end
    endgenerate
    assign comb[0] = integ[N];
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            cnt     <= 16'h0000;
            o_valid <= 1'b0;
            o_word  <= '0;
        end else begin
            o_valid <= tick;
            if (i_bit_valid)
                cnt <= tick ? 16'h0000 : cnt + 16'h0001;
            if (tick)
                o_word <= comb[N];
        end
    end
endmodule
`default_nettype wire

/* core/sdadc_sequencer.sv */
// Conversion sequencer, register port and interrupt for the delta-sigma ADC.
// Assumes a modulator bit stream and start pulse from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module sdadc_sequencer #(
    parameter int RES_W = 20
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // Modulator and start
    input  wire logic        i_mod_bit,
    input  wire logic        i_mod_clk_en,
    input  wire logic        i_soc,
    output logic             o_mod_reset,
    // Completion
    output logic             o_eoc,
    output logic             o_irq
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] soc_sync;
    logic [1:0] bit_sync;
    logic [1:0] ven_sync;
    logic       soc_last;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            soc_sync <= 2'b00;
            bit_sync <= 2'b00;
            ven_sync <= 2'b00;
            soc_last <= 1'b0;
        end else begin
            soc_sync <= {soc_sync[0], i_soc};
            bit_sync <= {bit_sync[0], i_mod_bit};
            ven_sync <= {ven_sync[0], i_mod_clk_en};
            soc_last <= soc_sync[1];
        end
    end
    logic ven_last;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            ven_last <= 1'b0;
        else
            ven_last <= ven_sync[1];
    end
    wire soc_rise  = soc_sync[1] && !soc_last;
    wire bit_valid = ven_sync[1] && !ven_last;
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    localparam int ST_W = sdadc_pkg::ST_WIDTH;
    logic                 enable;
    sdadc_pkg::mode_e     mode;
    sdadc_pkg::res_e      res;
    logic [ST_W-1:0]      status;
    logic [ST_W-1:0]      mask;
    logic [RES_W-1:0]     result;
    logic [15:0]          ratio_ovr;
    wire wr_ctrl   = i_wr && (i_addr == sdadc_pkg::ADDR_CTRL);
    wire wr_mask   = i_wr && (i_addr == sdadc_pkg::ADDR_MASK);
    wire wr_decim  = i_wr && (i_addr == sdadc_pkg::ADDR_DECIM);
    wire rd_status = i_rd && (i_addr == sdadc_pkg::ADDR_STATUS);
    wire rd_result = i_rd && (i_addr == sdadc_pkg::ADDR_RESULT);
    wire sw_start  = wr_ctrl && i_wdata[sdadc_pkg::CTRL_START_BIT];
    // A start written together with the enable bit counts at once
    wire start_evt = (sw_start && i_wdata[sdadc_pkg::CTRL_EN_BIT]) || (enable && soc_rise);
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            enable    <= 1'b0;
            mode      <= sdadc_pkg::MODE_SINGLE;
            res       <= sdadc_pkg::RES_16;
            mask      <= '0;
            ratio_ovr <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                enable <= i_wdata[sdadc_pkg::CTRL_EN_BIT];
                mode   <= sdadc_pkg::mode_e'(i_wdata[sdadc_pkg::CTRL_MODE_LSB +: 2]);
                res    <= sdadc_pkg::res_e'(i_wdata[sdadc_pkg::CTRL_RES_LSB +: 2]);
            end
            if (wr_mask)
                mask <= i_wdata[ST_W-1:0];
            if (wr_decim)
                ratio_ovr <= i_wdata[15:0];
        end
    end
    // ------------------------------------------------------------
    // Resolution against rate
    // ------------------------------------------------------------
    logic [15:0] ratio_def;
    always_comb begin
        unique case (res)
            sdadc_pkg::RES_8:  ratio_def = sdadc_pkg::DECIM_8;
            sdadc_pkg::RES_12: ratio_def = sdadc_pkg::DECIM_12;
            sdadc_pkg::RES_16: ratio_def = sdadc_pkg::DECIM_16;
            sdadc_pkg::RES_20: ratio_def = sdadc_pkg::DECIM_20;
        endcase
    end
    wire [15:0] ratio = (ratio_ovr != 16'h0000) ? ratio_ovr : ratio_def;
    wire        hi_res = (res == sdadc_pkg::RES_20);
    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    sdadc_pkg::seq_e state;
    sdadc_pkg::seq_e next_state;
    logic [2:0]      prime_cnt;
    logic [2:0]      next_prime_cnt;
    logic            dec_clear;
    logic            dec_valid;
    logic [sdadc_pkg::ACC_W-1:0] dec_word;
    logic            conv_done;
    wire reprime = (mode == sdadc_pkg::MODE_MULTI) ||
                   ((mode == sdadc_pkg::MODE_TURBO) && !hi_res);
    always_comb begin
        next_state     = state;
        next_prime_cnt = prime_cnt;
        dec_clear      = 1'b0;
        conv_done      = 1'b0;
        unique case (state)
            sdadc_pkg::SEQ_STANDBY: begin
                dec_clear = 1'b1;
                if (start_evt) begin
                    next_state     = sdadc_pkg::SEQ_PRIME;
                    next_prime_cnt = 3'h0;
                end
            end
            sdadc_pkg::SEQ_PRIME: begin
                if (dec_valid) begin
                    next_prime_cnt = prime_cnt + 3'h1;
                    if (prime_cnt == sdadc_pkg::PRIME_CONV - 3'h1)
                        next_state = sdadc_pkg::SEQ_RUN;
                end
            end
            sdadc_pkg::SEQ_RUN: begin
                if (dec_valid) begin
                    conv_done = 1'b1;
                    if (mode == sdadc_pkg::MODE_SINGLE) begin
                        next_state = sdadc_pkg::SEQ_STANDBY;
                    end else if (reprime) begin
                        dec_clear      = 1'b1;
                        next_state     = sdadc_pkg::SEQ_PRIME;
                        next_prime_cnt = 3'h0;
                    end
                end
            end
            default: next_state = sdadc_pkg::SEQ_STANDBY;
        endcase
        if (!enable && !start_evt) begin
            next_state = sdadc_pkg::SEQ_STANDBY;
            dec_clear  = 1'b1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state     <= sdadc_pkg::SEQ_STANDBY;
            prime_cnt <= 3'h0;
        end else begin
            state     <= next_state;
            prime_cnt <= next_prime_cnt;
        end
    end
    sinc4_decimator #(
        .W           (sdadc_pkg::ACC_W)
    ) u_decim (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_clear     (dec_clear),
        .i_ratio     (ratio),
        .i_bit_valid (bit_valid),
        .i_bit       (bit_sync[1]),
        .o_valid     (dec_valid),
        .o_word      (dec_word)
    );
    // Scale result to top bits of the chosen resolution
    logic [5:0] shift;
    always_comb begin
        unique case (res)
            sdadc_pkg::RES_8:  shift = 6'd9;
            sdadc_pkg::RES_12: shift = 6'd9;
            sdadc_pkg::RES_16: shift = 6'd13;
            sdadc_pkg::RES_20: shift = 6'd41;
        endcase
    end
    wire [sdadc_pkg::ACC_W-1:0] scaled = dec_word >> shift;
    // ------------------------------------------------------------
    // Result, status and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            result <= '0;
            status <= '0;
        end else begin
            if (conv_done)
                result <= scaled[RES_W-1:0];
            // Set wins over the read clear
            status[sdadc_pkg::ST_EOC_BIT] <= conv_done ||
                (status[sdadc_pkg::ST_EOC_BIT] && !rd_result && !rd_status);
            status[sdadc_pkg::ST_OVR_BIT] <= (conv_done && status[sdadc_pkg::ST_EOC_BIT] && !rd_result) ||
                (status[sdadc_pkg::ST_OVR_BIT] && !rd_status);
        end
    end
    logic eoc_hold;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            eoc_hold <= 1'b0;
        else
            eoc_hold <= conv_done || (eoc_hold && !rd_result);
    end
    assign o_eoc       = eoc_hold;
    assign o_irq       = |(status & mask);
    assign o_mod_reset = dec_clear;
    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    wire [31:0] ctrl_word = {26'h000_0000, res, mode, enable, 1'b0};
    wire [31:0] st_word   = {30'h0000_0000, status};
    wire [31:0] mask_word = {30'h0000_0000, mask};
    wire [31:0] res_word  = {{(32-RES_W){1'b0}}, result};
    wire [31:0] dec_rword = {16'h0000, ratio_ovr};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = sdadc_pkg::ZERO_WORD;
        case (i_addr)
            sdadc_pkg::ADDR_CTRL:   rd_mux = ctrl_word;
            sdadc_pkg::ADDR_STATUS: rd_mux = st_word;
            sdadc_pkg::ADDR_MASK:   rd_mux = mask_word;
            sdadc_pkg::ADDR_RESULT: rd_mux = res_word;
            sdadc_pkg::ADDR_DECIM:  rd_mux = dec_rword;
            default:                rd_mux = sdadc_pkg::ZERO_WORD;
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            o_rdata <= sdadc_pkg::ZERO_WORD;
        else
            o_rdata <= i_rd ? rd_mux : sdadc_pkg::ZERO_WORD;
    end
endmodule
`default_nettype wire

/* testbench/sdadc_mod_src.sv */
// Modulator bit stream source for the conversion sequencer.
// Assumes the bench clock and reset; the stream runs freely.
`timescale 1ns/1ps
`default_nettype none
module sdadc_mod_src (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Modulator stream
    output logic      o_strobe,
    output logic      o_bit
);
    logic [3:0] cnt;
    // One input signal only, never switched mid-run
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
    assign o_strobe = cnt[1];
    assign o_bit    = cnt[3] ^ cnt[0];
endmodule
`default_nettype wire

/* testbench/sdadc_seq_properties.sv */
// Port checker for the conversion sequencer.
// Assumes it is bound to the sequencer top module.
`timescale 1ns/1ps
`default_nettype none
module sdadc_seq_props (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    // Register port
    input wire logic [3:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    // Completion
    input wire logic        o_mod_reset,
    input wire logic        o_eoc,
    input wire logic        o_irq
);
    logic [5:0] ctl;
    logic [1:0] msk;
    wire        rd_res = i_rd && i_addr == sdadc_pkg::ADDR_RESULT;
    wire        rep = ctl[3:2] == sdadc_pkg::MODE_MULTI
                    || (ctl[3:2] == sdadc_pkg::MODE_TURBO && ctl[5:4] != sdadc_pkg::RES_20);
    wire        cont = ctl[3:2] == sdadc_pkg::MODE_CONT
                    || (ctl[3:2] == sdadc_pkg::MODE_TURBO && ctl[5:4] == sdadc_pkg::RES_20);
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctl <= 6'h20;
            msk <= 2'h0;
        end else if (i_wr) begin
            if (i_addr == sdadc_pkg::ADDR_CTRL) ctl <= i_wdata[5:0];
            if (i_addr == sdadc_pkg::ADDR_MASK) msk <= i_wdata[1:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000) else $error("read data outside slot");
    a_result_clears: assert property (rd_res |=> !o_eoc) else $error("eoc kept after result read");
    a_eoc_holds: assert property (o_eoc && !rd_res |=> o_eoc) else $error("eoc dropped unread");
    a_irq_masked: assert property (msk == 2'b00 |-> !o_irq) else $error("irq while masked");
    a_irq_on_eoc: assert property ($rose(o_eoc) && msk[0] |-> o_irq) else $error("no irq on eoc");
    a_start_runs: assert property (i_wr && i_addr == sdadc_pkg::ADDR_CTRL && i_wdata[1:0] == 2'b11 && o_mod_reset
        |=> !o_mod_reset) else $error("start ignored");
    a_off_standby: assert property (!ctl[1] |-> o_mod_reset) else $error("runs while disabled");
    a_single_idle: assert property ($rose(o_eoc) && ctl[3:2] == sdadc_pkg::MODE_SINGLE |-> ##[0:1] o_mod_reset)
        else $error("single mode not idle");
    a_multi_reprime: assert property ($rose(o_eoc) && rep |-> $past(o_mod_reset) or ##[0:1] o_mod_reset)
        else $error("no reprime");
    a_cont_runs: assert property ($rose(o_eoc) && cont |-> !o_mod_reset) else $error("continuous reprimed");
endmodule
bind sdadc_sequencer sdadc_seq_props chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mod_reset(o_mod_reset), .o_eoc(o_eoc), .o_irq(o_irq));
`default_nettype wire

/* testbench/sigma_delta_adc_sequencer_tb.sv */
// Self-checking bench for the conversion sequencer.
// Assumes the modulator source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module sigma_delta_adc_sequencer_tb;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_soc = 1'b0;
    logic [31:0] o_rdata;
    logic        mod_bit, mod_stb, o_mod_reset, o_eoc, o_irq;
    int          failures = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          t, t0;
    logic [4:0]  rows [5];
    logic [1:0]  m, r;
    logic        lg;
    logic [31:0] d;
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;
    sdadc_sequencer uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_mod_bit(mod_bit), .i_mod_clk_en(mod_stb), .i_soc(i_soc),
        .o_mod_reset(o_mod_reset), .o_eoc(o_eoc), .o_irq(o_irq));
    sdadc_mod_src modsrc (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_strobe(mod_stb), .o_bit(mod_bit));
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task automatic wait_eoc(output int n);
        n = 0;
        while (o_eoc !== 1'b1 && n < 600) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= 600) failures++;
    endtask
    task automatic results;
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        results();
    end
    initial begin
        rows = '{{sdadc_pkg::MODE_SINGLE, sdadc_pkg::RES_16, 1'b0},
                 {sdadc_pkg::MODE_CONT, sdadc_pkg::RES_12, 1'b0},
                 {sdadc_pkg::MODE_MULTI, sdadc_pkg::RES_8, 1'b1},
                 {sdadc_pkg::MODE_TURBO, sdadc_pkg::RES_16, 1'b1},
                 {sdadc_pkg::MODE_TURBO, sdadc_pkg::RES_20, 1'b0}};
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(sdadc_pkg::ADDR_CTRL, d);
        `CHK(d, 32'h0000_0020)
        rd(4'hF, d);
        `CHK({d, o_mod_reset}, 33'h0_0000_0001)
        wr(sdadc_pkg::ADDR_DECIM, 32'h0000_0002);
        for (int k = 0; k < 5; k++) begin
            {m, r, lg} = rows[k];
            wr(sdadc_pkg::ADDR_CTRL, {26'h0, r, m, 2'b11});
            wait_eoc(t);
            t0 = cyc;
            `CHK({t > 24, o_irq}, 2'b10)
            rd(sdadc_pkg::ADDR_STATUS, d);
            `CHK(d[0], 1'b1)
            rd(sdadc_pkg::ADDR_RESULT, d);
            `CHK({d[31:20], o_eoc}, 13'h0000)
            if (m == sdadc_pkg::MODE_SINGLE) begin
                repeat (80) @(posedge i_clk);
                `CHK({o_eoc, o_mod_reset}, 2'b01)
            end else begin
                wait_eoc(t);
                `CHK(cyc - t0 > 20, lg)
            end
            wr(sdadc_pkg::ADDR_CTRL, 32'h0000_0000);
            rd(sdadc_pkg::ADDR_RESULT, d);
        end
        rd(sdadc_pkg::ADDR_STATUS, d);
        wr(sdadc_pkg::ADDR_MASK, 32'h0000_0001);
        `CHK(o_irq, 1'b0)
        wr(sdadc_pkg::ADDR_CTRL, 32'h0000_0022);
        i_soc <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_soc <= 1'b0;
        wait_eoc(t);
        `CHK(o_irq, 1'b1)
        rd(sdadc_pkg::ADDR_STATUS, d);
        `CHK({o_eoc, o_irq}, 2'b10)
        rd(sdadc_pkg::ADDR_RESULT, d);
        `CHK(o_eoc, 1'b0)
        wr(sdadc_pkg::ADDR_CTRL, 32'h0000_000B);
        repeat (10) @(posedge i_clk);
        wr(sdadc_pkg::ADDR_CTRL, 32'h0000_0000);
        repeat (100) @(posedge i_clk);
        `CHK({o_eoc, o_mod_reset}, 2'b01)
        results();
    end
endmodule
`default_nettype wire
